//--- inc/buck_ctrl_pkg.sv
/*
 * constants for the step-down regulator supervisory control: clock rates,
 * switching periods, protection counts, strap codes, register map.
 * assumes a 25 MHz system clock and comparator inputs from the analog side.
 */
package buck_ctrl_pkg;

	// system clock
	localparam int CLK_KHZ = 25000;
	localparam int CLK_PERIOD_NS = 40;

	// switching frequencies and their periods in clock cycles
	localparam int SW_1100_KHZ = 1100;
	localparam int SW_1000_KHZ = 1000;
	localparam int SW_800_KHZ = 800;
	localparam logic [5:0] PER_1100 = 6'(CLK_KHZ / SW_1100_KHZ);
	localparam logic [5:0] PER_1000 = 6'(CLK_KHZ / SW_1000_KHZ);
	localparam logic [5:0] PER_800 = 6'(CLK_KHZ / SW_800_KHZ);

	// on-time below which current is taken from the low side (rounded down)
	localparam int SHORT_ON_NS = 130;
	localparam logic [5:0] SHORT_ON_CYC =
		6'((SHORT_ON_NS / CLK_PERIOD_NS) > 0 ?
		(SHORT_ON_NS / CLK_PERIOD_NS) : 1);

	// lowest equivalent frequency allowed while skipping
	localparam int AUDIO_MIN_KHZ = 25;
	localparam logic [5:0] MAX_SKIP = 6'(SW_800_KHZ / AUDIO_MIN_KHZ - 1);

	// first-level overcurrent cycles in a row that trip protection
	localparam logic [2:0] OC1_TRIP_COUNT = 3'h4;

	// sync input silent this long means no partner
	localparam logic [6:0] SYNC_LOST_CYC = 7'(2 * (CLK_KHZ / SW_800_KHZ));

	// strap comparator codes; 6 and 7 mean pin floating
	localparam logic [2:0] STRAP_0R = 3'h0;
	localparam logic [2:0] STRAP_24K = 3'h1;
	localparam logic [2:0] STRAP_56K = 3'h2;
	localparam logic [2:0] STRAP_110K = 3'h3;
	localparam logic [2:0] STRAP_180K = 3'h4;

	typedef enum logic [1:0] {freq_1100, freq_1000, freq_800} freq_t;

	// asynchronous input vector positions
	localparam int IN_ENABLE = 0;
	localparam int IN_VCC_OK = 1;
	localparam int IN_VIN_OK = 2;
	localparam int IN_FB_OVER = 3;
	localparam int IN_FB_BELOW_DIS = 4;
	localparam int IN_FB_UNDER = 5;
	localparam int IN_FB_WINDOW = 6;
	localparam int IN_OC_LVL1 = 7;
	localparam int IN_OC_LVL2 = 8;
	localparam int IN_I_LOW = 9;
	localparam int IN_TEMP_HOT = 10;
	localparam int IN_TEMP_COOL = 11;
	localparam int IN_SS_DONE = 12;
	localparam int IN_SYNC = 13;
	localparam int IN_LOOP_HS = 14;
	localparam int IN_LOOP_LS = 15;
	localparam int IN_LIGHT = 16;
	localparam int IN_STRAP = 17;
	localparam int N_ASYNC = 20;

	// register map, byte addresses
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h04;
	localparam logic [7:0] REG_CONFIG = 8'h08;

	// status bits
	localparam int ST_OVP = 0;
	localparam int ST_UVP = 1;
	localparam int ST_OCP = 2;
	localparam int ST_HOT = 3;
	localparam int ST_PG = 4;
	localparam int ST_LOCK = 5;
	localparam int ST_LOW_SENSE = 6;
	localparam int ST_OC_CNT = 8;

	// control bits and reset value
	localparam int CT_SKIP_ALLOW = 0;
	localparam int CT_SYNC_ALLOW = 1;
	localparam logic [1:0] CONTROL_RESET = 2'h3;

	// config bits
	localparam int CF_SKIP = 0;
	localparam int CF_MASTER = 1;
	localparam int CF_FREQ = 2;

endpackage

//--- rtl/buck_protection_sync_control.sv
/*
 * supervisory control of a synchronous step-down regulator: protection,
 * power-good, sense selection, interleaved sync, strap decode, ahb-lite regs.
 * assumes comparator inputs are asynchronous and a single 25 MHz clock.
 */
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
// Function
// R1 - arm overvoltage check when enabled and both supplies out of lockout
// R2 - feedback above overvoltage threshold forces high side off at once
// R3 - in overvoltage, low side on until feedback at 0.3 V; again on recross
// R4 - overvoltage fault latched; cleared only by enable or signal supply cycle
// R5 - undervoltage check armed only after soft-start completes
// R6 - armed and feedback below 0.48 V: undervoltage fault, request soft-off
// R7 - undervoltage latched until enable, signal or power supply cycles
// R8 - release power-good after soft-start once output regulates
// R9 - power-good low outside window, disabled, lockout or any protection; only vcc_ok lockout pulls it low, vin_ok low alone does not
// R10 - arm overcurrent check when enabled and both supplies good
// R11 - sense high side normally, low side when on-time under 130 ns
// R12 - first-level overcurrent ends high pulse, low side on until next cycle
// R13 - four first-level events in four consecutive cycles trip overcurrent
// R14 - second-level overcurrent trips protection immediately
// R15 - on trip: high off, low on until 600 mA, then both off, latched
// R16 - thermal: both off at 140 C, fresh soft-start at 100 C, unlatched
// R17 - no sync when sync pin floats; run from own switching clock
// R18 - master drives sync pin with own switching clock shifted 180 degrees
// R19 - slave takes sync pin as input and locks its clock to it
// R20 - pulse skipping at light load keeping frequency above audio band
// R21 - strap resistor decodes into six skip, role and frequency settings
// R22 - latched trip stays off until enable or signal supply cycles
// R23 - synchronise comparators; protection commands override the loop
`timescale 1ns/1ps

module buck_protection_sync_control
	import buck_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// supplies and enable
	input wire logic enable,
	input wire logic vcc_ok,
	input wire logic vin_ok,
	// feedback comparators
	input wire logic fb_over_ovp,
	input wire logic fb_below_discharge,
	input wire logic fb_under_uvp,
	input wire logic fb_in_window,
	// current and temperature comparators
	input wire logic oc_level1,
	input wire logic oc_level2,
	input wire logic current_below_600ma,
	input wire logic temp_hot,
	input wire logic temp_cool,
	// soft-start and regulation loop
	input wire logic soft_start_done,
	input wire logic loop_high_req,
	input wire logic loop_low_req,
	input wire logic light_load,
	// strap comparator code
	input wire logic [2:0] config_resistor,
	// switch commands and sequencing
	output logic high_side_switch,
	output logic low_side_switch,
	output logic soft_off_request,
	output logic soft_start_restart,
	output logic sense_low_side,
	// power-good, open drain
	output logic power_good_flag_out,
	output logic power_good_flag_oe,
	// sync pin
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);

////////////////////////////////////////////////////////////////////////////
// input synchronisers

	logic [N_ASYNC-1:0] raw;
	logic [N_ASYNC-1:0] meta_q;
	logic [N_ASYNC-1:0] s_q;

	assign raw = {config_resistor, light_load, loop_low_req, loop_high_req,
		sync_in, soft_start_done, temp_cool, temp_hot, current_below_600ma,
		oc_level2, oc_level1, fb_in_window, fb_under_uvp, fb_below_discharge,
		fb_over_ovp, vin_ok, vcc_ok, enable};

	// no reset: stages fill during reset, so the strap is valid at release
	always_ff @(posedge clock) begin // see R23
		meta_q <= raw;
		s_q <= meta_q;
	end

	logic armed;
	logic clear_latch;
	assign armed = s_q[IN_ENABLE] & s_q[IN_VCC_OK] & s_q[IN_VIN_OK];
	// enable or signal supply low is the cycle that clears latches
	assign clear_latch = ~s_q[IN_ENABLE] | ~s_q[IN_VCC_OK];

////////////////////////////////////////////////////////////////////////////
// strap decode, caught once after reset

	logic strap_taken_q;
	logic skip_strap_q;
	logic master_q;
	freq_t freq_q;

	always_ff @(posedge clock) begin // see R21
		if (reset) begin
			strap_taken_q <= 1'b0;
			skip_strap_q <= 1'b0;
			master_q <= 1'b1;
			freq_q <= freq_1100;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			unique case (s_q[IN_STRAP +: 3])
				STRAP_0R: begin
					skip_strap_q <= 1'b0;
					master_q <= 1'b0;
					freq_q <= freq_1100;
				end
				STRAP_24K: begin
					skip_strap_q <= 1'b1;
					master_q <= 1'b0;
					freq_q <= freq_1100;
				end
				STRAP_56K: begin
					skip_strap_q <= 1'b0;
					master_q <= 1'b0;
					freq_q <= freq_800;
				end
				STRAP_110K: begin
					skip_strap_q <= 1'b0;
					master_q <= 1'b1;
					freq_q <= freq_1000;
				end
				STRAP_180K: begin
					skip_strap_q <= 1'b1;
					master_q <= 1'b1;
					freq_q <= freq_1100;
				end
				default: begin
					skip_strap_q <= 1'b0;
					master_q <= 1'b1;
					freq_q <= freq_1100;
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////
// registers reachable over the bus

	logic [1:0] control_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic addr_phase;

	assign addr_phase = hsel & htrans[1] & hready;

	always_ff @(posedge clock) begin
		if (reset) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			control_q <= CONTROL_RESET;
		end else begin
			wr_pend_q <= addr_phase & hwrite;
			if (addr_phase)
				wr_addr_q <= haddr[7:0];
			if (wr_pend_q && wr_addr_q == REG_CONTROL)
				control_q <= hwdata[1:0];
		end
	end

////////////////////////////////////////////////////////////////////////////
// switching clock, sync pin

	logic [5:0] period;
	logic [5:0] sw_cnt_q;
	logic sync_prev_q;
	logic sync_rise;
	logic lock_q;
	logic [6:0] lost_cnt_q;
	logic slave_sync;
	logic cycle_start;

	always_comb begin
		unique case (freq_q)
			freq_1000: period = PER_1000;
			freq_800: period = PER_800;
			default: period = PER_1100;
		endcase
	end

	assign sync_rise = s_q[IN_SYNC] & ~sync_prev_q;
	assign slave_sync = ~master_q & control_q[CT_SYNC_ALLOW];
	assign cycle_start = sw_cnt_q == 6'h00;

	// a lone slave with a floating pin sees no edges and free-runs
	always_ff @(posedge clock) begin // see R17
		if (reset) begin
			sync_prev_q <= 1'b0;
			lock_q <= 1'b0;
			lost_cnt_q <= '0;
		end else begin
			sync_prev_q <= s_q[IN_SYNC];
			if (slave_sync && sync_rise) begin
				lock_q <= 1'b1;
				lost_cnt_q <= '0;
			end else if (lost_cnt_q == SYNC_LOST_CYC) begin
				lock_q <= 1'b0;
			end else begin
				lost_cnt_q <= lost_cnt_q + 7'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			sw_cnt_q <= '0;
		else if (slave_sync && sync_rise)
			sw_cnt_q <= '0; // see R19
		else if (sw_cnt_q >= period - 6'h01)
			sw_cnt_q <= '0;
		else
			sw_cnt_q <= sw_cnt_q + 6'h01;
	end

	// pin driven only by a master, so two slaves never fight
	always_ff @(posedge clock) begin // see R18
		if (reset) begin
			sync_out <= 1'b0;
			sync_oe <= 1'b0;
		end else begin
			sync_oe <= master_q & control_q[CT_SYNC_ALLOW];
			sync_out <= sw_cnt_q >= (period >> 1);
		end
	end

////////////////////////////////////////////////////////////////////////////
// pulse skipping and sense selection

	logic skip_q;
	logic [5:0] skip_cnt_q;
	logic [5:0] on_cnt_q;

	always_ff @(posedge clock) begin // see R20
		if (reset) begin
			skip_q <= 1'b0;
			skip_cnt_q <= '0;
		end else if (cycle_start) begin
			if (skip_strap_q && control_q[CT_SKIP_ALLOW] &&
				s_q[IN_LIGHT] && skip_cnt_q < MAX_SKIP) begin
				skip_q <= 1'b1;
				skip_cnt_q <= skip_cnt_q + 6'h01;
			end else begin
				skip_q <= 1'b0;
				skip_cnt_q <= '0;
			end
		end
	end

	always_ff @(posedge clock) begin // see R11
		if (reset) begin
			on_cnt_q <= '0;
			sense_low_side <= 1'b0;
		end else if (cycle_start) begin
			sense_low_side <= on_cnt_q < SHORT_ON_CYC;
			on_cnt_q <= '0;
		end else if (high_side_switch && on_cnt_q != 6'h3f) begin
			on_cnt_q <= on_cnt_q + 6'h01;
		end
	end

////////////////////////////////////////////////////////////////////////////
// protection latches

	logic ovp_q;
	logic ovp_low_q;
	logic uvp_q;
	logic ocp_q;
	logic ocp_low_q;
	logic oc1_cycle_q;
	logic oc1_seen_q;
	logic [2:0] oc1_cnt_q;
	logic hot_q;

	always_ff @(posedge clock) begin
		if (reset || clear_latch) begin // see R4
			ovp_q <= 1'b0;
			ovp_low_q <= 1'b0;
		end else if (armed && s_q[IN_FB_OVER]) begin // see R1
			ovp_q <= 1'b1;
			ovp_low_q <= 1'b1; // see R3
		end else if (s_q[IN_FB_BELOW_DIS]) begin
			ovp_low_q <= 1'b0; // see R3
		end
	end

	always_ff @(posedge clock) begin
		if (reset || clear_latch || !s_q[IN_VIN_OK])
			uvp_q <= 1'b0; // see R7
		else if (armed && s_q[IN_SS_DONE] && s_q[IN_FB_UNDER])
			uvp_q <= 1'b1; // see R5
	end

	always_ff @(posedge clock) begin // see R12
		if (reset || !armed) begin
			oc1_cycle_q <= 1'b0;
			oc1_seen_q <= 1'b0;
			oc1_cnt_q <= '0;
		end else if (cycle_start) begin
			oc1_cycle_q <= s_q[IN_OC_LVL1];
			oc1_seen_q <= s_q[IN_OC_LVL1];
			// a cycle with no event restarts the run
			if (oc1_seen_q)
				oc1_cnt_q <= oc1_cnt_q + 3'h1; // see R13
			else
				oc1_cnt_q <= '0;
		end else if (s_q[IN_OC_LVL1]) begin
			oc1_cycle_q <= 1'b1;
			oc1_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || clear_latch) begin // see R22
			ocp_q <= 1'b0;
			ocp_low_q <= 1'b0;
		end else if (armed && !ocp_q &&
			(s_q[IN_OC_LVL2] || oc1_cnt_q == OC1_TRIP_COUNT)) begin // see R14
			ocp_q <= 1'b1; // see R10
			ocp_low_q <= 1'b1;
		end else if (ocp_q && s_q[IN_I_LOW]) begin
			ocp_low_q <= 1'b0; // see R15
		end
	end

	// thermal is not latched: it ends by itself and restarts soft-start
	always_ff @(posedge clock) begin // see R16
		if (reset) begin
			hot_q <= 1'b0;
			soft_start_restart <= 1'b0;
		end else begin
			soft_start_restart <= hot_q & s_q[IN_TEMP_COOL];
			if (s_q[IN_TEMP_HOT])
				hot_q <= 1'b1;
			else if (s_q[IN_TEMP_COOL])
				hot_q <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////
// switch commands, protection first

	always_ff @(posedge clock) begin // see R23
		if (reset) begin
			high_side_switch <= 1'b0;
			low_side_switch <= 1'b0;
		end else if (hot_q || s_q[IN_TEMP_HOT] || uvp_q || !armed) begin
			high_side_switch <= 1'b0;
			low_side_switch <= 1'b0;
		end else if (ocp_q || s_q[IN_OC_LVL2]) begin
			high_side_switch <= 1'b0; // see R14
			low_side_switch <= ocp_low_q | s_q[IN_OC_LVL2]; // see R15
		end else if (ovp_q || s_q[IN_FB_OVER]) begin
			high_side_switch <= 1'b0; // see R2
			low_side_switch <= ovp_low_q | s_q[IN_FB_OVER];
		end else if (oc1_cycle_q || s_q[IN_OC_LVL1]) begin
			high_side_switch <= 1'b0; // see R12
			low_side_switch <= 1'b1;
		end else if (skip_q) begin
			high_side_switch <= 1'b0;
			low_side_switch <= 1'b0;
		end else begin
			high_side_switch <= s_q[IN_LOOP_HS];
			low_side_switch <= s_q[IN_LOOP_LS] & ~s_q[IN_LOOP_HS];
		end
	end

	always_ff @(posedge clock) begin // see R6
		if (reset)
			soft_off_request <= 1'b0;
		else
			soft_off_request <= uvp_q | (ocp_q & ~ocp_low_q) | clear_latch;
	end

////////////////////////////////////////////////////////////////////////////
// power-good

	logic pg_ok;
	// raw hot input too, so the flag drops with the switches
	assign pg_ok = s_q[IN_SS_DONE] & s_q[IN_FB_WINDOW] & s_q[IN_ENABLE] &
		s_q[IN_VCC_OK] & ~(ovp_q | uvp_q | ocp_q | hot_q | s_q[IN_TEMP_HOT]);

	always_ff @(posedge clock) begin // see R9
		if (reset) begin
			power_good_flag_out <= 1'b0;
			power_good_flag_oe <= 1'b1;
		end else begin
			power_good_flag_out <= 1'b0;
			power_good_flag_oe <= ~pg_ok; // see R8
		end
	end

////////////////////////////////////////////////////////////////////////////
// bus read side

	logic [31:0] rd_word;

	always_comb begin
		rd_word = '0;
		unique case (haddr[7:0])
			REG_STATUS: begin
				rd_word[ST_OVP] = ovp_q;
				rd_word[ST_UVP] = uvp_q;
				rd_word[ST_OCP] = ocp_q;
				rd_word[ST_HOT] = hot_q;
				rd_word[ST_PG] = ~power_good_flag_oe;
				rd_word[ST_LOCK] = lock_q;
				rd_word[ST_LOW_SENSE] = sense_low_side;
				rd_word[ST_OC_CNT +: 3] = oc1_cnt_q;
			end
			REG_CONTROL: rd_word[1:0] = control_q;
			REG_CONFIG: begin
				rd_word[CF_SKIP] = skip_strap_q;
				rd_word[CF_MASTER] = master_q;
				rd_word[CF_FREQ +: 2] = freq_q;
			end
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_phase && !hwrite)
				hrdata <= rd_word;
		end
	end

endmodule

//--- test/buck_ctrl_assertions.sv
/*
 * concurrent checks on the regulator control's ports.
 * assumes comparator inputs settle 3 edges after a change.
 */
`timescale 1ns/1ps

module buck_ctrl_assertions(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// comparators
	input wire logic enable,
	input wire logic vcc_ok,
	input wire logic vin_ok,
	input wire logic fb_over_ovp,
	input wire logic fb_under_uvp,
	input wire logic fb_in_window,
	input wire logic oc_level2,
	input wire logic current_below_600ma,
	input wire logic temp_hot,
	// outputs
	input wire logic high_side_switch,
	input wire logic low_side_switch,
	input wire logic soft_off_request,
	input wire logic power_good_flag_out,
	input wire logic power_good_flag_oe,
	input wire logic hreadyout,
	input wire logic hresp
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// no thermal or undervoltage override active
	wire armed = enable && vcc_ok && vin_ok && !temp_hot && !fb_under_uvp;

	//////////////////////////////////////////////////////////////////////
	hs_over_off_a: assert property (
		fb_over_ovp[*4] |-> !high_side_switch) else $error("hs on in ovp");
	ovp_ls_on_a: assert property (
		!enable ##1 (armed && !oc_level2 && fb_over_ovp)[*8]
		|-> low_side_switch) else $error("ls off in ovp");
	therm_off_a: assert property (
		temp_hot[*4] |-> !high_side_switch && !low_side_switch)
		else $error("switch on while hot");
	off_unarmed_a: assert property (
		(!enable)[*4] |-> !high_side_switch && !low_side_switch
		&& soft_off_request) else $error("switching while disabled");
	pg_low_a: assert property (
		(!enable || !vcc_ok || !fb_in_window || temp_hot)[*4]
		|-> power_good_flag_oe) else $error("pg released wrongly");
	pg_drain_a: assert property (
		power_good_flag_out == 1'b0) else $error("pg driven high");
	oc2_hs_off_a: assert property (
		oc_level2[*4] |-> !high_side_switch) else $error("hs on at oc2");
	ocp_hold_a: assert property (
		!enable ##1 (armed && oc_level2 && !current_below_600ma)[*8]
		|-> low_side_switch) else $error("ls off before drain");
	ocp_done_a: assert property (
		(armed && oc_level2)[*4] ##1
		(armed && current_below_600ma && !oc_level2)[*8]
		|-> !high_side_switch && !low_side_switch)
		else $error("switch on after drain");
	bus_okay_a: assert property (
		hreadyout && !hresp) else $error("bus not ready or error");
endmodule

//--- test/sync_partner.sv
/*
 * second regulator as master on the shared sync pin.
 * assumes a pull-down holds the pin low while it is silent.
 */
`timescale 1ns/1ps

module sync_partner(
	// control
	input wire logic run,
	// pin drive
	output logic sync_drive
);
	// 320 ns link clock only while run; silent pin reads low
	initial begin
		sync_drive = 1'b0;
		forever begin
			#160;
			sync_drive = run ? !sync_drive : 1'b0;
		end
	end
endmodule

//--- test/testbench.sv
/*
 * self-checking bench for the regulator control: straps, sync, protection.
 * assumes the bus slave answers OKAY with zero wait states.
 */
`timescale 1ns/1ps
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	bad_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module testbench;
	import buck_ctrl_pkg::*;
	logic clock, reset, enable, vcc_ok, vin_ok, fb_over_ovp, fb_below_discharge;
	logic fb_under_uvp, fb_in_window, oc_level1, oc_level2, current_below_600ma;
	logic temp_hot, temp_cool, soft_start_done, loop_high_req, loop_low_req;
	logic light_load, hsel, hwrite, hready, sync_run, sync_drive;
	logic [2:0] config_resistor, hsize;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic high_side_switch, low_side_switch, soft_off_request;
	logic soft_start_restart, sense_low_side, power_good_flag_out;
	logic power_good_flag_oe, sync_out, sync_oe, hreadyout, hresp;
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	logic [3:0] cfgs [6] = '{4'h0, 4'h1, 4'h8, 4'h6, 4'h3, 4'h2};
	int bad_count, checks_done, restarts, n;
	// pin level: our drive wins, else the partner's
	wire sync_pin = sync_oe ? sync_out : sync_drive;
	// one slave, so its ready is the bus ready
	assign hready = hreadyout;

	buck_protection_sync_control i_buck_protection_sync_control(
		.clock(clock), .reset(reset), .enable(enable), .vcc_ok(vcc_ok),
		.vin_ok(vin_ok), .fb_over_ovp(fb_over_ovp),
		.fb_below_discharge(fb_below_discharge), .fb_under_uvp(fb_under_uvp),
		.fb_in_window(fb_in_window), .oc_level1(oc_level1),
		.oc_level2(oc_level2), .current_below_600ma(current_below_600ma),
		.temp_hot(temp_hot), .temp_cool(temp_cool),
		.soft_start_done(soft_start_done), .loop_high_req(loop_high_req),
		.loop_low_req(loop_low_req), .light_load(light_load),
		.config_resistor(config_resistor),
		.high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
		.soft_off_request(soft_off_request),
		.soft_start_restart(soft_start_restart),
		.sense_low_side(sense_low_side),
		.power_good_flag_out(power_good_flag_out),
		.power_good_flag_oe(power_good_flag_oe), .sync_in(sync_pin),
		.sync_out(sync_out), .sync_oe(sync_oe), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	sync_partner i_sync_partner(.run(sync_run), .sync_drive(sync_drive));

	//////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (soft_start_restart === 1'b1) restarts <= restarts + 1;
	end
	initial begin
		// generous: the whole run needs about 900 cycles
		#800000;
		bad_count++;
		end_of_test();
	end

	//////////////////////////////////////////////////////////////////////
	task w(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task bus(input logic [7:0] a, input logic wr, input logic [31:0] v);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do w(1); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= v;
		do w(1); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task rst;
		reset <= 1'b1;
		w(6);
		reset <= 1'b0;
		w(1);
	endtask
	task cyc_en;
		enable <= 1'b0;
		w(4);
		enable <= 1'b1;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////
	task t_regs;
		bus(REG_CONTROL, 1'b0, 32'h0);
		`CK("control reset", CONTROL_RESET, d[1:0])
		bus(REG_CONTROL, 1'b1, 32'h0);
		bus(REG_CONTROL, 1'b0, 32'h0);
		`CK("control written", 32'h0, d)
		bus(8'h0c, 1'b0, 32'h0);
		`CK("unmapped", 32'h0, d)
		$display("regs done");
	endtask
	task t_strap;
		for (int i = 0; i < 6; i++) begin
			config_resistor <= codes[i];
			rst();
			bus(REG_CONFIG, 1'b0, 32'h0);
			`CK("config", cfgs[i], d[3:0])
			`CK("sync drive", cfgs[i][1], sync_oe)
			if (cfgs[i][0]) begin
				light_load <= 1'b1;
				loop_high_req <= 1'b1;
				w(30);
				`CK("skip", 1'b0, high_side_switch)
				light_load <= 1'b0;
				loop_high_req <= 1'b0;
			end
			if (cfgs[i][1]) begin
				// begin at a rising edge so n spans one whole period
				while (sync_out !== 1'b0) w(1);
				while (sync_out !== 1'b1) w(1);
				n = 0;
				do begin w(1); n++; end while (sync_out === 1'b1);
				do begin w(1); n++; end while (sync_out !== 1'b1);
				`CK("period", cfgs[i][2] ? PER_1000 : PER_1100, 6'(n))
			end
		end
		$display("strap done");
	endtask
	task t_slave;
		config_resistor <= STRAP_0R;
		rst();
		sync_run <= 1'b1;
		w(40);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("locked", 1'b1, d[ST_LOCK])
		sync_run <= 1'b0;
		w(80);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("free run", 1'b0, d[ST_LOCK])
		config_resistor <= 3'h7;
		rst();
		$display("slave done");
	endtask
	task t_pg;
		w(5);
		`CK("pg good", 1'b0, power_good_flag_oe)
		`CK("sense low", 1'b1, sense_low_side)
		fb_in_window <= 1'b0;
		w(5);
		`CK("pg window", 1'b1, power_good_flag_oe)
		fb_in_window <= 1'b1;
		vcc_ok <= 1'b0;
		w(5);
		`CK("pg lockout", 1'b1, power_good_flag_oe)
		vcc_ok <= 1'b1;
		$display("pg done");
	endtask
	task t_ovp;
		vin_ok <= 1'b0;
		fb_over_ovp <= 1'b1;
		w(5);
		fb_over_ovp <= 1'b0;
		vin_ok <= 1'b1;
		loop_high_req <= 1'b1;
		w(5);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("ovp unarmed", 1'b0, d[ST_OVP])
		`CK("hs loop", 1'b1, high_side_switch)
		cyc_en();
		fb_over_ovp <= 1'b1;
		w(9);
		`CK("hs ovp", 1'b0, high_side_switch)
		`CK("ls ovp", 1'b1, low_side_switch)
		fb_over_ovp <= 1'b0;
		fb_below_discharge <= 1'b1;
		w(5);
		`CK("ls released", 1'b0, low_side_switch)
		fb_below_discharge <= 1'b0;
		fb_over_ovp <= 1'b1;
		w(5);
		`CK("ls recross", 1'b1, low_side_switch)
		fb_over_ovp <= 1'b0;
		w(5);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("ovp latched", 1'b1, d[ST_OVP])
		`CK("pg ovp", 1'b1, power_good_flag_oe)
		cyc_en();
		w(5);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("ovp cleared", 1'b0, d[ST_OVP])
		$display("ovp done");
	endtask
	task t_uvp;
		soft_start_done <= 1'b0;
		fb_under_uvp <= 1'b1;
		w(6);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("uvp early", 1'b0, d[ST_UVP])
		w(30);
		`CK("sense high", 1'b0, sense_low_side)
		soft_start_done <= 1'b1;
		w(5);
		`CK("soft off", 1'b1, soft_off_request)
		fb_under_uvp <= 1'b0;
		w(5);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("uvp latched", 1'b1, d[ST_UVP])
		vin_ok <= 1'b0;
		w(4);
		vin_ok <= 1'b1;
		w(5);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("uvp cleared", 1'b0, d[ST_UVP])
		$display("uvp done");
	endtask
	task t_ocp;
		cyc_en();
		oc_level2 <= 1'b1;
		w(9);
		`CK("ocp hs", 1'b0, high_side_switch)
		`CK("ocp ls", 1'b1, low_side_switch)
		oc_level2 <= 1'b0;
		current_below_600ma <= 1'b1;
		w(9);
		`CK("ocp drained", 1'b0, low_side_switch)
		current_below_600ma <= 1'b0;
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("ocp latched", 1'b1, d[ST_OCP])
		cyc_en();
		w(5);
		// 44 cycles spans at most three switching periods
		oc_level1 <= 1'b1;
		w(5);
		`CK("oc1 hs", 1'b0, high_side_switch)
		`CK("oc1 ls", 1'b1, low_side_switch)
		w(39);
		oc_level1 <= 1'b0;
		w(30);
		oc_level1 <= 1'b1;
		w(44);
		oc_level1 <= 1'b0;
		w(5);
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("oc1 no trip", 1'b0, d[ST_OCP])
		oc_level1 <= 1'b1;
		w(140);
		oc_level1 <= 1'b0;
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("oc1 trip", 1'b1, d[ST_OCP])
		cyc_en();
		$display("ocp done");
	endtask
	task t_hot;
		temp_hot <= 1'b1;
		w(5);
		`CK("hot off", 2'h0, {high_side_switch, low_side_switch})
		temp_hot <= 1'b0;
		w(3);
		restarts = 0;
		temp_cool <= 1'b1;
		w(6);
		temp_cool <= 1'b0;
		`CK("restart", 1, restarts)
		bus(REG_STATUS, 1'b0, 32'h0);
		`CK("hot cleared", 1'b0, d[ST_HOT])
		$display("thermal done");
	endtask

	//////////////////////////////////////////////////////////////////////
	initial begin
		{reset, enable, vcc_ok, vin_ok, fb_in_window, hsel} = 6'h3f;
		{fb_over_ovp, fb_below_discharge, fb_under_uvp, oc_level1} = 4'h0;
		{oc_level2, current_below_600ma, temp_hot, temp_cool} = 4'h0;
		{loop_high_req, loop_low_req, light_load, hwrite, sync_run} = 5'h0;
		soft_start_done = 1'b1;
		config_resistor = 3'h7;
		hsize = 3'h2;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		bad_count = 0;
		checks_done = 0;
		restarts = 0;
		rst();
		t_pg();
		t_regs();
		t_strap();
		t_slave();
		t_ovp();
		t_uvp();
		t_ocp();
		t_hot();
		end_of_test();
	end
endmodule

bind buck_protection_sync_control buck_ctrl_assertions i_buck_ctrl_assertions(
	.clock(clock), .reset(reset), .enable(enable), .vcc_ok(vcc_ok),
	.vin_ok(vin_ok), .fb_over_ovp(fb_over_ovp), .fb_under_uvp(fb_under_uvp),
	.fb_in_window(fb_in_window), .oc_level2(oc_level2),
	.current_below_600ma(current_below_600ma), .temp_hot(temp_hot),
	.high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
	.soft_off_request(soft_off_request),
	.power_good_flag_out(power_good_flag_out),
	.power_good_flag_oe(power_good_flag_oe), .hreadyout(hreadyout),
	.hresp(hresp));
